// ---- design/tvcu_pkg.sv ----
// Package: constants and carriers of the trap vector and context unit
package tvcu_pkg;
    localparam int          TVCU_DW          = 16;
    localparam int          TVCU_NREG        = 16;
    localparam int          TVCU_NALT        = 2;
    localparam int          TVCU_AW          = 24;
    localparam int          TVCU_NIRQ        = 245;
    localparam int          TVCU_NTRAP       = 7;
    localparam int          TVCU_BSL_W       = 13;
    localparam int          TVCU_IPL_W       = 3;
    localparam int          TVCU_SP_IDX      = 15;
    localparam logic [23:0] TVCU_SEG_UNIT    = 24'h000400;
    localparam logic [23:0] TVCU_OFS_OSC     = 24'h000004;
    localparam logic [23:0] TVCU_OFS_ADDR    = 24'h000006;
    localparam logic [23:0] TVCU_OFS_HARD    = 24'h000008;
    localparam logic [23:0] TVCU_OFS_STACK   = 24'h00000a;
    localparam logic [23:0] TVCU_OFS_MATH    = 24'h00000c;
    localparam logic [23:0] TVCU_OFS_DMA     = 24'h00000e;
    localparam logic [23:0] TVCU_OFS_SOFT    = 24'h000010;
    localparam logic [23:0] TVCU_OFS_IRQ0    = 24'h000014;
    localparam logic [23:0] TVCU_OFS_IRQ_LAST = 24'h0001fc;
    localparam logic [2:0]  TVCU_CTX_PRIMARY = 3'h0;
    localparam logic [15:0] TVCU_REG_RST     = 16'h0000;
    // Trap request bit positions; lower index wins
    localparam int          TVCU_TR_OSC      = 0;
    localparam int          TVCU_TR_ADDR     = 1;
    localparam int          TVCU_TR_HARD     = 2;
    localparam int          TVCU_TR_STACK    = 3;
    localparam int          TVCU_TR_MATH     = 4;
    localparam int          TVCU_TR_DMA      = 5;
    localparam int          TVCU_TR_SOFT     = 6;

    typedef struct packed {
        logic [2:0] ctx_b;
        logic [2:0] ctx_a;
    } tvcu_alt_cfg_type;

    typedef struct packed {
        logic [2:0] manual_context_index;
        logic [2:0] current_context_index;
    } tvcu_ctx_stat_type;

    typedef struct packed {
        logic        valid;
        logic        is_trap;
        logic [7:0]  index;
        logic [23:0] addr;
    } tvcu_vec_type;
endpackage

// ---- design/tvcu_vec_sel.sv ----
// Pending-request arbiter and vector slot address generator
`timescale 1ns/1ps
module tvcu_vec_sel
    import tvcu_pkg::*;
#(
    parameter int NIRQ = TVCU_NIRQ
) (
    input  wire logic [TVCU_NTRAP-1:0] trap_pend,
    input  wire logic [NIRQ-1:0]       irq_pend,
    input  wire logic [TVCU_BSL_W-1:0] boot_segment_limit,
    output tvcu_vec_type               sel
);
    logic [23:0] base;
    logic [23:0] trap_ofs [TVCU_NTRAP];
    logic [7:0]  trap_idx;
    logic [7:0]  irq_idx;
    logic        trap_any;
    logic        irq_any;

    // Base = (limit - 1) * 0x400
    assign base = 24'((24'(boot_segment_limit) - 24'h000001) * TVCU_SEG_UNIT);

    assign trap_ofs[TVCU_TR_OSC]   = TVCU_OFS_OSC;
    assign trap_ofs[TVCU_TR_ADDR]  = TVCU_OFS_ADDR;
    assign trap_ofs[TVCU_TR_HARD]  = TVCU_OFS_HARD;
    assign trap_ofs[TVCU_TR_STACK] = TVCU_OFS_STACK;
    assign trap_ofs[TVCU_TR_MATH]  = TVCU_OFS_MATH;
    assign trap_ofs[TVCU_TR_DMA]   = TVCU_OFS_DMA;
    assign trap_ofs[TVCU_TR_SOFT]  = TVCU_OFS_SOFT;

    assign trap_any = |trap_pend;
    assign irq_any  = |irq_pend;

    // Fixed priority: lowest index first, one winner per entry
    always_comb begin
        trap_idx = 8'h00;
        for (int i = TVCU_NTRAP - 1; i >= 0; i--) begin
            if (trap_pend[i]) begin
                trap_idx = 8'(i);
            end
        end
    end

    always_comb begin
        irq_idx = 8'h00;
        for (int i = NIRQ - 1; i >= 0; i--) begin
            if (irq_pend[i]) begin
                irq_idx = 8'(i);
            end
        end
    end

    // Reserved slots 0, 2 and 0x12 are never produced by either path
    always_comb begin
        sel.valid   = trap_any | irq_any;
        sel.is_trap = trap_any;
        sel.index   = trap_any ? trap_idx : irq_idx;
        if (trap_any) begin
            sel.addr = 24'(base + trap_ofs[trap_idx[2:0]]);
        end else if (irq_any) begin
            sel.addr = 24'(base + TVCU_OFS_IRQ0 + {15'h0000, irq_idx, 1'b0});
        end else begin
            sel.addr = 24'h000000;
        end
    end
endmodule

// ---- design/tvcu_top.sv ----
// Trap vector, working register file and context set control
// Operation
// - Oscillator fail trap vectors at offset 0x4
// - Address error trap vectors at offset 0x6
// - Generic hard trap vectors at offset 0x8
// - Stack error trap vectors at offset 0xA
// - Math error trap vectors at offset 0xC
// - DMA controller error trap at offset 0xE
// - Generic soft trap vectors at offset 0x10
// - Interrupt n vectors at 0x14 plus 2n
// - Sixteen 16-bit general working registers
// - Last register is the software stack pointer
// - Two alternate sets, switched by priority level
// - Set priority from 3-bit configuration fields
// - Alternate sets keep contents between uses
// - Swap instruction switches sets explicitly
// - Status reports current and manual set
// - Interrupts accepted inside loops, resume correctly
// - Base is (limit minus one) times 0x400
`timescale 1ns/1ps
module tvcu_top
    import tvcu_pkg::*;
#(
    parameter int NIRQ = TVCU_NIRQ
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic [TVCU_NTRAP-1:0] trap_req,
    input  wire logic [NIRQ-1:0]       irq_req,
    input  wire logic [TVCU_IPL_W-1:0] irq_ipl,
    input  wire logic                  entry_ack,
    input  wire logic                  ret_ack,
    input  wire logic [TVCU_BSL_W-1:0] boot_segment_limit,
    input  tvcu_alt_cfg_type           alt_register_config_word,
    input  wire logic                  context_swap_instruction,
    input  wire logic [2:0]            swap_target,
    input  wire logic                  loop_active,
    input  wire logic [23:0]           loop_resume_pc,
    input  wire logic [3:0]            rd_addr_a,
    input  wire logic [3:0]            rd_addr_b,
    input  wire logic                  wr_en,
    input  wire logic [3:0]            wr_addr,
    input  wire logic [TVCU_DW-1:0]    wr_data,
    output logic                       vec_valid,
    output logic                       vec_is_trap,
    output logic [7:0]                 vec_index,
    output logic [23:0]                vec_addr,
    output logic [TVCU_DW-1:0]         rd_data_a,
    output logic [TVCU_DW-1:0]         rd_data_b,
    output logic [TVCU_DW-1:0]         software_stack_pointer,
    output tvcu_ctx_stat_type          context_status_register,
    output logic                       loop_saved,
    output logic [23:0]                loop_ret_pc
);
    // ------------------------------------------------------------
    // Pending requests
    // ------------------------------------------------------------
    logic [TVCU_NTRAP-1:0] trap_pend_ff;
    logic [TVCU_NTRAP-1:0] nxt_trap_pend;
    logic [NIRQ-1:0]       irq_pend_ff;
    logic [NIRQ-1:0]       nxt_irq_pend;
    logic [TVCU_NTRAP-1:0] trap_clr;
    logic [NIRQ-1:0]       irq_clr;
    tvcu_vec_type          sel;
    tvcu_vec_type          vec_ff;
    tvcu_vec_type          nxt_vec;
    logic                  trap_taken;
    logic                  irq_taken;

    tvcu_vec_sel #(
        .NIRQ(NIRQ)
    ) u_sel (
        .trap_pend          (trap_pend_ff),
        .irq_pend           (irq_pend_ff),
        .boot_segment_limit (boot_segment_limit),
        .sel                (sel)
    );

    // Only the serviced source is cleared; a new request in the same cycle wins
    assign trap_taken    = entry_ack && vec_ff.valid && vec_ff.is_trap;
    assign irq_taken     = entry_ack && vec_ff.valid && !vec_ff.is_trap;

    genvar gt;
    genvar gi;
    generate
        for (gt = 0; gt < TVCU_NTRAP; gt++) begin : g_trap_clr
            assign trap_clr[gt] = trap_taken && (vec_ff.index == 8'(gt));
        end
        for (gi = 0; gi < NIRQ; gi++) begin : g_irq_clr
            assign irq_clr[gi] = irq_taken && (vec_ff.index == 8'(gi));
        end
    endgenerate

    assign nxt_trap_pend = (trap_pend_ff & ~trap_clr) | trap_req;
    assign nxt_irq_pend  = (irq_pend_ff & ~irq_clr) | irq_req;
    // Offer drops on the taking edge so one entry never serves two sources
    assign nxt_vec       = entry_ack ? '0 : sel;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trap_pend_ff <= '0;
        end else begin
            trap_pend_ff <= nxt_trap_pend;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_pend_ff <= '0;
        end else begin
            irq_pend_ff <= nxt_irq_pend;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vec_ff <= '0;
        end else begin
            vec_ff <= nxt_vec;
        end
    end

    assign vec_valid   = vec_ff.valid;
    assign vec_is_trap = vec_ff.is_trap;
    assign vec_index   = vec_ff.index;
    assign vec_addr    = vec_ff.addr;

    // ------------------------------------------------------------
    // Context selection
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TVCU_CS_PRI = 3'b001,
        TVCU_CS_ALT = 3'b010,
        TVCU_CS_MAN = 3'b100
    } tvcu_cs_type;

    tvcu_cs_type cs_ff;
    tvcu_cs_type nxt_cs;
    logic [2:0]  cur_ctx_ff;
    logic [2:0]  nxt_cur_ctx;
    logic [2:0]  man_ctx_ff;
    logic [2:0]  nxt_man_ctx;
    logic [2:0]  saved_ctx_ff;
    logic [2:0]  nxt_saved_ctx;
    logic        irq_entry;
    logic        hit_a;
    logic        hit_b;
    logic        swap_ok;

    assign irq_entry = entry_ack && vec_ff.valid && !vec_ff.is_trap;
    // Level 0 and 7 never map to an alternate set
    assign hit_a     = (alt_register_config_word.ctx_a == irq_ipl) && (irq_ipl != 3'h0)
                       && (irq_ipl != 3'h7);
    assign hit_b     = (alt_register_config_word.ctx_b == irq_ipl) && (irq_ipl != 3'h0)
                       && (irq_ipl != 3'h7) && !hit_a;
    assign swap_ok   = context_swap_instruction && (swap_target <= 3'(TVCU_NALT));

    always_comb begin
        nxt_cs        = cs_ff;
        nxt_cur_ctx   = cur_ctx_ff;
        nxt_man_ctx   = man_ctx_ff;
        nxt_saved_ctx = saved_ctx_ff;
        case (cs_ff)
            TVCU_CS_PRI, TVCU_CS_MAN: begin
                if (irq_entry && (hit_a || hit_b)) begin
                    nxt_saved_ctx = cur_ctx_ff;
                    nxt_cur_ctx   = hit_a ? 3'h1 : 3'h2;
                    nxt_cs        = TVCU_CS_ALT;
                end else if (swap_ok) begin
                    nxt_cur_ctx = swap_target;
                    nxt_man_ctx = swap_target;
                    nxt_cs      = (swap_target == TVCU_CTX_PRIMARY) ? TVCU_CS_PRI : TVCU_CS_MAN;
                end
            end
            TVCU_CS_ALT: begin
                if (ret_ack) begin
                    nxt_cur_ctx = saved_ctx_ff;
                    nxt_cs      = (saved_ctx_ff == TVCU_CTX_PRIMARY) ? TVCU_CS_PRI : TVCU_CS_MAN;
                end else if (swap_ok) begin
                    nxt_cur_ctx = swap_target;
                    nxt_man_ctx = swap_target;
                end
            end
            default: begin
                nxt_cs      = TVCU_CS_PRI;
                nxt_cur_ctx = TVCU_CTX_PRIMARY;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cs_ff <= TVCU_CS_PRI;
        end else begin
            cs_ff <= nxt_cs;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur_ctx_ff <= TVCU_CTX_PRIMARY;
        end else begin
            cur_ctx_ff <= nxt_cur_ctx;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            man_ctx_ff <= TVCU_CTX_PRIMARY;
        end else begin
            man_ctx_ff <= nxt_man_ctx;
        end
    end

    // One saved level only: alternate entries do not nest
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            saved_ctx_ff <= TVCU_CTX_PRIMARY;
        end else begin
            saved_ctx_ff <= nxt_saved_ctx;
        end
    end

    assign context_status_register.current_context_index = cur_ctx_ff;
    assign context_status_register.manual_context_index  = man_ctx_ff;

    // ------------------------------------------------------------
    // Working register banks
    // ------------------------------------------------------------
    // Bank 0 is primary; banks 1..NALT shadow registers 0..14 only
    logic [TVCU_DW-1:0] bank_ff [TVCU_NALT+1][TVCU_NREG-1];
    logic [TVCU_DW-1:0] sp_ff;
    logic [1:0]         bank_sel;
    logic [TVCU_DW-1:0] rd_a_ff;
    logic [TVCU_DW-1:0] rd_b_ff;
    logic [TVCU_DW-1:0] nxt_rd_a;
    logic [TVCU_DW-1:0] nxt_rd_b;

    assign bank_sel = cur_ctx_ff[1:0];

    genvar gb;
    genvar gr;
    generate
        for (gb = 0; gb <= TVCU_NALT; gb++) begin : g_bank
            for (gr = 0; gr < TVCU_NREG - 1; gr++) begin : g_reg
                // Only the active bank is written, so idle banks persist
                always_ff @(posedge clk or negedge nrst) begin
                    if (!nrst) begin
                        bank_ff[gb][gr] <= TVCU_REG_RST;
                    end else if (wr_en && wr_addr == 4'(gr) && bank_sel == 2'(gb)) begin
                        bank_ff[gb][gr] <= wr_data;
                    end
                end
            end
        end
    endgenerate

    // Stack pointer is shared by all sets so context saves stay coherent
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sp_ff <= TVCU_REG_RST;
        end else if (wr_en && wr_addr == 4'(TVCU_SP_IDX)) begin
            sp_ff <= wr_data;
        end
    end

    assign nxt_rd_a = (rd_addr_a == 4'(TVCU_SP_IDX)) ? sp_ff
                      : bank_ff[bank_sel][rd_addr_a];
    assign nxt_rd_b = (rd_addr_b == 4'(TVCU_SP_IDX)) ? sp_ff
                      : bank_ff[bank_sel][rd_addr_b];

    // Registered reads: data shows one edge after the address
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_a_ff <= TVCU_REG_RST;
            rd_b_ff <= TVCU_REG_RST;
        end else begin
            rd_a_ff <= nxt_rd_a;
            rd_b_ff <= nxt_rd_b;
        end
    end

    assign rd_data_a = rd_a_ff;
    assign rd_data_b = rd_b_ff;
    assign software_stack_pointer = sp_ff;

    // ------------------------------------------------------------
    // Loop resume capture
    // ------------------------------------------------------------
    // Entry is never held off by a loop; its resume point is kept instead
    logic        loop_saved_ff;
    logic [23:0] loop_pc_ff;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loop_saved_ff <= 1'b0;
            loop_pc_ff    <= 24'h000000;
        end else if (entry_ack && vec_ff.valid && loop_active) begin
            loop_saved_ff <= 1'b1;
            loop_pc_ff    <= loop_resume_pc;
        end else if (ret_ack) begin
            loop_saved_ff <= 1'b0;
        end
    end

    assign loop_saved  = loop_saved_ff;
    assign loop_ret_pc = loop_pc_ff;
endmodule

// ---- tb/tvcu_seq_model.sv ----
// Sequencer stand-in that takes offered vectors promptly or slowly
`timescale 1ns/1ps
module tvcu_seq_model (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic vec_valid,
    input  wire logic slow,
    output logic      entry_ack
);
    logic wait_ff;
    // Falling-edge update keeps ack settled at the sampling edge
    always_ff @(negedge clk or negedge nrst) begin
        if (!nrst) begin
            entry_ack <= 1'b0;
            wait_ff   <= 1'b0;
        end else begin
            wait_ff   <= slow && vec_valid && !wait_ff;
            entry_ack <= vec_valid && !entry_ack && (!slow || wait_ff);
        end
    end
endmodule

// ---- tb/tvcu_monitor.sv ----
// Concurrent checks on the trap vector and context unit ports
`timescale 1ns/1ps
module tvcu_monitor
    import tvcu_pkg::*;
#(
    parameter int NIRQ = TVCU_NIRQ
) (
    input wire logic          clk,
    input wire logic          nrst,
    input wire logic [2:0]    irq_ipl,
    input wire logic          entry_ack,
    input wire logic          ret_ack,
    input wire logic [12:0]   boot_segment_limit,
    input tvcu_alt_cfg_type   alt_register_config_word,
    input wire logic          context_swap_instruction,
    input wire logic [2:0]    swap_target,
    input wire logic          loop_active,
    input wire logic [23:0]   loop_resume_pc,
    input wire logic          vec_valid,
    input wire logic          vec_is_trap,
    input wire logic [7:0]    vec_index,
    input wire logic [23:0]   vec_addr,
    input tvcu_ctx_stat_type  context_status_register,
    input wire logic          loop_saved,
    input wire logic [23:0]   loop_ret_pc
);
    // ----------------------------------------
    // Helpers and properties
    // ----------------------------------------
    wire logic [23:0] base    = ({11'h000, boot_segment_limit} - 24'h000001) << 10;
    wire logic [23:0] step    = {15'h0000, vec_index, 1'b0};
    wire logic        quiet   = !(vec_valid && entry_ack) && !ret_ack;
    // Levels 0 and 7 never select an alternate set
    wire logic [2:0]  alt_set = (irq_ipl == 3'h0 || irq_ipl == 3'h7) ? 3'h0 :
                                (irq_ipl == alt_register_config_word.ctx_a) ? 3'h1 :
                                (irq_ipl == alt_register_config_word.ctx_b) ? 3'h2 : 3'h0;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    trap_slot_a:
    assert property (vec_valid && vec_is_trap && $past(boot_segment_limit, 2) == boot_segment_limit
        |-> vec_addr == base + 24'h000004 + step)
        else $error("trap vector address wrong");
    irq_slot_a:
    assert property (vec_valid && !vec_is_trap && $past(boot_segment_limit, 2) == boot_segment_limit
        |-> vec_addr == base + 24'h000014 + step)
        else $error("interrupt vector address wrong");
    slot_range_a:
    assert property (vec_valid |-> (vec_is_trap ? vec_index < 8'h07 : vec_index < NIRQ))
        else $error("vector index outside its slots");
    entry_clears_a:
    assert property (vec_valid && entry_ack |=> !vec_valid)
        else $error("offer not withdrawn after entry");
    swap_sets_a:
    assert property (context_swap_instruction && swap_target <= 3'h2 && quiet
        |=> context_status_register == {2{$past(swap_target)}}) else $error("swap did not select set");
    swap_ignore_a:
    assert property (context_swap_instruction && swap_target > 3'h2 && quiet
        |=> $stable(context_status_register)) else $error("bad swap target changed status");
    alt_entry_a:
    assert property (vec_valid && entry_ack && !vec_is_trap && context_status_register == 6'h00
        |=> context_status_register.current_context_index == $past(alt_set)) else $error("wrong set on entry");
    loop_save_a:
    assert property (vec_valid && entry_ack && loop_active
        |=> loop_saved && loop_ret_pc == $past(loop_resume_pc)) else $error("loop resume point lost");
endmodule
bind tvcu_top tvcu_monitor #(.NIRQ(NIRQ)) u_tvcu_monitor (
    .clk(clk), .nrst(nrst), .irq_ipl(irq_ipl), .entry_ack(entry_ack), .ret_ack(ret_ack),
    .boot_segment_limit(boot_segment_limit), .alt_register_config_word(alt_register_config_word),
    .context_swap_instruction(context_swap_instruction), .swap_target(swap_target),
    .loop_active(loop_active), .loop_resume_pc(loop_resume_pc), .vec_valid(vec_valid),
    .vec_is_trap(vec_is_trap), .vec_index(vec_index), .vec_addr(vec_addr),
    .context_status_register(context_status_register), .loop_saved(loop_saved), .loop_ret_pc(loop_ret_pc));

// ---- tb/tvcu_top_bench.sv ----
// Self-checking bench for the trap vector and context unit
`timescale 1ns/1ps
module tvcu_top_bench
    import tvcu_pkg::*;
;
    logic                  clk = 1'b0, nrst = 1'b0, ret_ack = 1'b0, swp = 1'b0, wr_en = 1'b0;
    logic                  loop_active = 1'b0, slow = 1'b0, entry_ack, vec_valid, vec_is_trap, loop_saved;
    logic [TVCU_NTRAP-1:0] trap_req = '0;
    logic [TVCU_NIRQ-1:0]  irq_req = '0;
    logic [2:0]            irq_ipl = 3'h0, swap_target = 3'h0;
    logic [12:0]           bsl = 13'h0001;
    tvcu_alt_cfg_type      cfg = {3'h5, 3'h3};
    logic [23:0]           pc = 24'h000000, vec_addr, loop_ret_pc;
    logic [3:0]            ra = 4'h0, wa = 4'h0;
    logic [15:0]           wd = 16'h0000, rda, rdb, sp;
    tvcu_ctx_stat_type     stat;
    logic [24:0]           exp_q[$];
    logic [31:0]           rng = 32'h8478;
    logic [2:0]            ipl_t [4] = '{3'h3, 3'h5, 3'h3, 3'h7};
    logic [2:0]            cur_t [4] = '{3'h1, 3'h2, 3'h1, 3'h0};
    logic [15:0]           dat_t [4] = '{TVCU_REG_RST, TVCU_REG_RST, 16'h2222, 16'h1111};
    int                    bad_count = 0, samples_checked = 0, i;

    always #2 clk = ~clk;
    tvcu_top #(.NIRQ(TVCU_NIRQ)) u_tvcu_top (
        .clk(clk), .nrst(nrst), .trap_req(trap_req), .irq_req(irq_req), .irq_ipl(irq_ipl),
        .entry_ack(entry_ack), .ret_ack(ret_ack), .boot_segment_limit(bsl), .alt_register_config_word(cfg),
        .context_swap_instruction(swp), .swap_target(swap_target), .loop_active(loop_active),
        .loop_resume_pc(pc), .rd_addr_a(ra), .rd_addr_b(ra), .wr_en(wr_en), .wr_addr(wa), .wr_data(wd),
        .vec_valid(vec_valid), .vec_is_trap(vec_is_trap), .vec_index(), .vec_addr(vec_addr),
        .rd_data_a(rda), .rd_data_b(rdb), .software_stack_pointer(sp), .context_status_register(stat),
        .loop_saved(loop_saved), .loop_ret_pc(loop_ret_pc));
    tvcu_seq_model u_tvcu_seq_model (.clk(clk), .nrst(nrst), .vec_valid(vec_valid), .slow(slow),
        .entry_ack(entry_ack));

    // ----------------------------------------
    // Checking and stimulus tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [24:0] slot(input logic t, input logic [7:0] n);
        logic [23:0] b;
        b = ({11'h000, bsl} - 24'h000001) << 10;
        return {t, b + (t ? 24'h000004 : 24'h000014) + {15'h0000, n, 1'b0}};
    endfunction
    // Offers taken by the sequencer are matched against the oldest note
    always @(posedge clk) begin
        if (nrst === 1'b1 && vec_valid === 1'b1 && entry_ack === 1'b1) begin
            if (exp_q.size() == 0) check({vec_is_trap, vec_addr}, 32'hffffffff);
            else check({vec_is_trap, vec_addr}, exp_q.pop_front());
        end
    end
    task automatic drain();
        for (int k = 0; k < 60 && exp_q.size() != 0; k++) @(negedge clk);
        if (exp_q.size() != 0) begin
            bad_count++;
            conclude();
        end else repeat (2) @(negedge clk);
    endtask
    task automatic raise(input logic t, input logic [7:0] n);
        exp_q.push_back(slot(t, n));
        if (t) trap_req[n[2:0]] = 1'b1;
        else irq_req[n] = 1'b1;
        @(negedge clk);
        trap_req = '0;
        irq_req = '0;
        drain();
    endtask
    task automatic pulse_cycle();
        @(negedge clk);
        swp = 1'b0;
        ret_ack = 1'b0;
        wr_en = 1'b0;
        @(negedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        wa = a;
        wd = d;
        wr_en = 1'b1;
        pulse_cycle();
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] d);
        ra = a;
        @(negedge clk);
        check({rda, rdb}, {d, d});
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(negedge clk);
        check({vec_valid, stat}, 7'h00);
        nrst = 1'b1;
        @(negedge clk);
        for (i = 0; i < 7; i++) begin
            slow = i[0];
            raise(1'b1, i[7:0]);
        end
        trap_req = 7'h7f;
        irq_req[0] = 1'b1;
        for (i = 0; i < 8; i++) exp_q.push_back(slot(i < 7, i < 7 ? i[7:0] : 8'h00));
        @(negedge clk);
        trap_req = '0;
        irq_req = '0;
        drain();
        for (i = 0; i < 12; i++) begin
            rng = xs(rng);
            bsl = rng[28:16];
            slow = rng[5];
            raise(1'b0, i == 0 ? 8'hf4 : rng[7:0] % 8'hf5);
        end
        wr(4'hf, 16'h5a5a);
        wr(4'h1, 16'h1111);
        for (i = 0; i < 4; i++) begin
            irq_ipl = ipl_t[i];
            raise(1'b0, i[7:0]);
            check(stat, {3'h0, cur_t[i]});
            check(sp, 16'h5a5a);
            rd(4'h1, dat_t[i]);
            wr(4'h1, 16'h2222);
            ret_ack = 1'b1;
            pulse_cycle();
        end
        for (i = 0; i < 8; i++) begin
            swap_target = i[2:0];
            swp = 1'b1;
            pulse_cycle();
            check(stat, i < 3 ? {i[2:0], i[2:0]} : 6'h12);
        end
        rng = xs(rng);
        pc = rng[23:0];
        loop_active = 1'b1;
        raise(1'b1, 8'h06);
        check({loop_saved, loop_ret_pc}, {1'b1, pc});
        loop_active = 1'b0;
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        check({loop_saved, vec_valid, stat}, 8'h00);
        nrst = 1'b1;
        @(negedge clk);
        check({loop_saved, vec_valid, stat}, 8'h00);
        conclude();
    end
endmodule
